// File: hdl/rcr_pkg.sv
// Purpose: constants shared by the reset cause recorder
// Assumes: one 20 MHz clock, 16-bit register bus
// Notes: register offsets are byte addresses on the plain register port
package rcr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // ----------------------------------------------------------------
    // reset cause status fields
    // ----------------------------------------------------------------
    localparam int BIT_TRAP = 15;
    localparam int BIT_ILLEGAL = 14;
    localparam int BIT_CFGMIS = 9;
    localparam int BIT_EXT = 7;
    localparam int BIT_SWR = 6;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BOR = 1;
    localparam int BIT_POR = 0;
    localparam logic [15:0] CAUSE_MASK = 16'hc2df;
    localparam logic [15:0] CAUSE_RESET = 16'h0003;
    localparam logic [15:0] CAUSE_BOR_VAL = 16'h0002;
    localparam logic [15:0] CAUSE_BOR_KEEP = 16'h0080;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int BIT_CFG_CHK_EN = 0;
    localparam int BIT_SEC_EN = 1;
    localparam logic [15:0] CTRL_MASK = 16'h0003;
    localparam logic [15:0] CTRL_RESET = 16'h0003;

    // ----------------------------------------------------------------
    // core facing encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] ILLEGAL_OPCODE = 8'h3f;
    localparam logic [3:0] HARD_TRAP_LO = 4'hd;
    localparam logic [3:0] HARD_TRAP_HI = 4'hf;
    localparam int NUM_WREG = 16;
    localparam int STACK_PTR_IDX = 15;

    // ----------------------------------------------------------------
    // timing: the reset pulse lasts one instruction cycle
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int RST_HOLD_NS = 50;
    localparam int RST_HOLD_CYC =
        (RST_HOLD_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

endpackage : rcr_pkg

// File: hdl/rcr_reset_cause_recorder.sv
// Purpose: gathers warm reset sources, drives the system reset line and
//          keeps the reset cause status register
// Assumes: all inputs synchronous to sys_clk; rst is the power-on reset
// Notes: the clock source is never touched by a warm reset here
//
// Notes on behaviour
// - reset instruction pulses reset, clock kept
// - reset instruction sets software reset flag
// - watchdog timeout asserts reset line immediately
// - timeout in sleep or idle only wakes
// - watchdog timeout sets its cause flag
// - lower hard trap during higher trap resets
// - trap conflict sets trap conflict flag
// - shadow mismatch of pin select resets
// - illegal conditions share one cause flag
// - upper byte 3fh executed resets device
// - uninitialized pointer register use resets device
// - flow change into restricted segment resets
// - most flags cleared only by power resets
// - software may set or clear every flag
// - external reset pin sets external flag
// - power-on reset sets power-on flag
// - brown-out reset sets brown-out flag
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module rcr_reset_cause_recorder #(
    parameter int PPS_W = 16,
    parameter int PC_W = 24,
    parameter logic [23:0] RESTRICT_LO = 24'h000200,
    parameter logic [23:0] RESTRICT_HI = 24'h0003ff
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic por_event,
    input wire logic bor_event,
    input wire logic external_reset_pin_n,
    input wire logic reset_instr_exec,
    input wire logic wdt_timeout,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic power_save_instruction_sleep_exec,
    input wire logic power_save_instruction_idle_exec,
    input wire logic wdt_clear_exec,
    input wire logic trap_busy,
    input wire logic [3:0] trap_busy_lvl,
    input wire logic trap_new,
    input wire logic [3:0] trap_new_lvl,
    input wire logic pps_wr,
    input wire logic [PPS_W-1:0] pps_wdata,
    input wire logic [PPS_W-1:0] pps_cells,
    input wire logic instr_exec,
    input wire logic [7:0] instr_upper,
    input wire logic wreg_wr,
    input wire logic [3:0] wreg_wr_idx,
    input wire logic wreg_ptr_use,
    input wire logic [3:0] wreg_ptr_idx,
    input wire logic flow_change,
    input wire logic [PC_W-1:0] flow_target,
    output logic system_reset_line,
    output logic clock_reinit,
    output logic wdt_wake,
    output logic [15:0] wreg_init_map
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (PPS_W < 1 || PC_W < 1 || PC_W > 24 || RESTRICT_LO > RESTRICT_HI)
    begin : g_bad_param
        $error("rcr_reset_cause_recorder: unusable parameters");
    end

    // ----------------------------------------------------------------
    // source detection
    // ----------------------------------------------------------------
    logic [15:0] cause_r;
    logic [15:0] cause_nxt;
    logic [15:0] ctrl_r;
    logic [PPS_W-1:0] pps_shadow_r;
    logic [15:0] init_r;
    logic system_reset_line_r;
    logic [3:0] hold_r;
    logic low_power;
    logic wdt_rst;
    logic trap_conflict;
    logic cfg_mismatch;
    logic illegal_op;
    logic uninit_use;
    logic sec_violation;
    logic illegal_any;
    logic ext_rst;
    logic warm_event;
    logic [23:0] target_ext;

    assign low_power = cpu_sleep | cpu_idle;
    assign wdt_rst = wdt_timeout & ~low_power;
    assign ext_rst = ~external_reset_pin_n;

    assign trap_conflict = trap_new & trap_busy &
        (trap_new_lvl >= rcr_pkg::HARD_TRAP_LO) &
        (trap_new_lvl <= rcr_pkg::HARD_TRAP_HI) &
        (trap_new_lvl < trap_busy_lvl);

    // a write cycle updates cells and shadow together, so skip it
    assign cfg_mismatch = ctrl_r[rcr_pkg::BIT_CFG_CHK_EN] & ~pps_wr &
        (pps_cells != pps_shadow_r);

    assign illegal_op = instr_exec &
        (instr_upper == rcr_pkg::ILLEGAL_OPCODE);
    assign uninit_use = wreg_ptr_use & ~init_r[wreg_ptr_idx];

    assign target_ext = 24'(flow_target);
    assign sec_violation = flow_change & ctrl_r[rcr_pkg::BIT_SEC_EN] &
        (target_ext >= RESTRICT_LO) &
        (target_ext <= RESTRICT_HI);

    assign illegal_any = illegal_op | uninit_use | sec_violation;
    assign warm_event = reset_instr_exec | trap_conflict | cfg_mismatch |
        illegal_any | ext_rst;

    // ----------------------------------------------------------------
    // system reset line
    // ----------------------------------------------------------------
    // the watchdog path is combinational so reset is not delayed by a clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            system_reset_line_r <= 1'b0;
            hold_r <= 4'h0;
        end else if (warm_event | wdt_rst) begin
            system_reset_line_r <= 1'b1;
            hold_r <= 4'(rcr_pkg::RST_HOLD_CYC - 1);
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end else begin
            system_reset_line_r <= 1'b0;
        end
    end

    assign system_reset_line = system_reset_line_r | wdt_rst | rst;
    // warm resets keep the running clock source
    assign clock_reinit = rst | por_event | bor_event;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdt_wake <= 1'b0;
        end else begin
            wdt_wake <= wdt_timeout & low_power;
        end
    end

    // ----------------------------------------------------------------
    // pin select shadow copy
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pps_shadow_r <= '0;
        end else if (pps_wr) begin
            pps_shadow_r <= pps_wdata;
        end
    end

    // ----------------------------------------------------------------
    // working register initialised map
    // ----------------------------------------------------------------
    // the stack pointer never counts as uninitialised
    always_ff @(posedge sys_clk) begin
        if (rst || system_reset_line_r || wdt_rst || por_event || bor_event) begin
            init_r <= 16'h0001 << rcr_pkg::STACK_PTR_IDX;
        end else if (wreg_wr) begin
            init_r[wreg_wr_idx] <= 1'b1;
        end
    end

    assign wreg_init_map = init_r;

    // ----------------------------------------------------------------
    // reset cause status
    // ----------------------------------------------------------------
    // order: software write, then instruction clears, then hardware sets,
    // so an event in the clear cycle is never lost
    always_comb begin
        cause_nxt = cause_r;
        if (reg_wr && reg_addr == rcr_pkg::ADDR_CAUSE) begin
            cause_nxt = reg_wdata & rcr_pkg::CAUSE_MASK;
        end
        if (power_save_instruction_sleep_exec | power_save_instruction_idle_exec | wdt_clear_exec) begin
            cause_nxt[rcr_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        if (reset_instr_exec) cause_nxt[rcr_pkg::BIT_SWR] = 1'b1;
        if (wdt_timeout) cause_nxt[rcr_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        if (trap_conflict) cause_nxt[rcr_pkg::BIT_TRAP] = 1'b1;
        if (cfg_mismatch) cause_nxt[rcr_pkg::BIT_CFGMIS] = 1'b1;
        if (illegal_any) cause_nxt[rcr_pkg::BIT_ILLEGAL] = 1'b1;
        if (ext_rst) cause_nxt[rcr_pkg::BIT_EXT] = 1'b1;
        if (power_save_instruction_sleep_exec) begin
            cause_nxt[rcr_pkg::BIT_SLEEP] = 1'b1;
        end
        if (power_save_instruction_idle_exec) begin
            cause_nxt[rcr_pkg::BIT_IDLE] = 1'b1;
        end
        // power resets override the rest; a pin reset in the same cycle
        // survives a brown-out, since only power-on may clear its flag
        if (bor_event) begin
            cause_nxt = (cause_nxt & rcr_pkg::CAUSE_BOR_KEEP) |
                rcr_pkg::CAUSE_BOR_VAL;
        end
        if (por_event) begin
            cause_nxt = rcr_pkg::CAUSE_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cause_r <= rcr_pkg::CAUSE_RESET;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= rcr_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == rcr_pkg::ADDR_CTRL) begin
            ctrl_r <= reg_wdata & rcr_pkg::CTRL_MASK;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (reg_addr)
                rcr_pkg::ADDR_CAUSE: reg_rdata <= cause_r;
                rcr_pkg::ADDR_CTRL: reg_rdata <= ctrl_r;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_swr_pulse: assert property (
        @(posedge sys_clk) disable iff (rst)
        reset_instr_exec ##1 !(warm_event | wdt_rst)
        |-> system_reset_line_r ##1 !system_reset_line_r)
        else $error("reset instruction did not pulse reset");

    a_swr_release: assert property (
        @(posedge sys_clk) disable iff (rst)
        (reset_instr_exec && !por_event && !bor_event) ##1
        !(warm_event | wdt_rst) |=> !system_reset_line_r)
        else $error("reset not released after one cycle");

    a_swr_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        reset_instr_exec && !por_event && !bor_event
        |=> cause_r[rcr_pkg::BIT_SWR])
        else $error("software reset flag not set");

    a_wdt_reset: assert property (
        @(posedge sys_clk) disable iff (rst)
        wdt_timeout && !cpu_sleep && !cpu_idle |-> system_reset_line)
        else $error("watchdog timeout did not reset");

    a_wdt_wake: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wdt_timeout && (cpu_sleep || cpu_idle) && !warm_event && !system_reset_line_r)
        |-> !system_reset_line ##1 wdt_wake)
        else $error("watchdog in sleep must wake without reset");

    a_wdt_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        wdt_timeout && !por_event && !bor_event
        |=> cause_r[rcr_pkg::BIT_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not set");

    a_trap_reset: assert property (
        @(posedge sys_clk) disable iff (rst)
        trap_new && trap_busy && trap_new_lvl == 4'hd &&
        trap_busy_lvl == 4'he |=> system_reset_line_r)
        else $error("trap conflict did not reset");

    a_trap_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        trap_conflict && !por_event && !bor_event
        |=> cause_r[rcr_pkg::BIT_TRAP])
        else $error("trap conflict flag not set");

    a_cfg_mismatch: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg_mismatch && !por_event && !bor_event
        |=> system_reset_line_r && cause_r[rcr_pkg::BIT_CFGMIS])
        else $error("configuration mismatch not handled");

    a_illegal_op: assert property (
        @(posedge sys_clk) disable iff (rst)
        instr_exec && instr_upper == 8'h3f && !por_event && !bor_event
        |=> system_reset_line_r && cause_r[rcr_pkg::BIT_ILLEGAL])
        else $error("illegal opcode not handled");

    a_uninit_wreg: assert property (
        @(posedge sys_clk) disable iff (rst)
        $past(system_reset_line_r) && wreg_ptr_use && wreg_ptr_idx != 4'hf
        |=> system_reset_line_r)
        else $error("uninitialized pointer use did not reset");

    a_sec_reset: assert property (
        @(posedge sys_clk) disable iff (rst)
        sec_violation && !por_event && !bor_event
        |=> system_reset_line_r && cause_r[rcr_pkg::BIT_ILLEGAL])
        else $error("security violation not handled");

    a_warm_keep: assert property (
        @(posedge sys_clk) disable iff (rst)
        cause_r[rcr_pkg::BIT_TRAP] && !por_event && !bor_event &&
        !(reg_wr && reg_addr == rcr_pkg::ADDR_CAUSE)
        |=> cause_r[rcr_pkg::BIT_TRAP])
        else $error("trap flag lost without power reset");

    a_sw_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == rcr_pkg::ADDR_CAUSE && !por_event &&
        !bor_event && !warm_event && !wdt_timeout &&
        !power_save_instruction_sleep_exec && !power_save_instruction_idle_exec && !wdt_clear_exec
        |=> cause_r == ($past(reg_wdata) & rcr_pkg::CAUSE_MASK))
        else $error("software write to cause register lost");

    a_ext_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        !external_reset_pin_n && !por_event |=> system_reset_line_r &&
        cause_r[rcr_pkg::BIT_EXT])
        else $error("external reset not recorded");

    a_por_value: assert property (
        @(posedge sys_clk) disable iff (rst)
        por_event |=> cause_r == rcr_pkg::CAUSE_RESET)
        else $error("power-on reset value wrong");

    a_power_save_instruction_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        power_save_instruction_idle_exec && !por_event && !bor_event
        |=> cause_r[rcr_pkg::BIT_IDLE] && (!cause_r[rcr_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]
        || $past(wdt_timeout)))
        else $error("power-save flags wrong");

endmodule : rcr_reset_cause_recorder

// File: tb/rcr_core_model.sv
// Purpose: core side stand-in: pin-select cells and a reset pulse count
// Assumes: the bench drives pin-select writes and the upset strobe
// Notes: cells hold across warm resets, as real latches would
`timescale 1ns/1ps

module rcr_core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic system_reset_line,
    input wire logic pps_wr,
    input wire logic [15:0] pps_wdata,
    input wire logic upset,
    output logic [15:0] pps_cells,
    output logic [7:0] rst_cnt
);
    logic line_r;

    // upset models a disturbed cell, the fault the shadow must catch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pps_cells <= 16'h0000;
        end else if (pps_wr) begin
            pps_cells <= pps_wdata;
        end else if (upset) begin
            pps_cells <= pps_cells ^ 16'h0001;
        end
    end

    // one count per rising edge, so a held reset counts once
    always_ff @(posedge sys_clk) begin
        line_r <= system_reset_line;
        if (rst) begin
            rst_cnt <= 8'h00;
        end else if (system_reset_line && !line_r) begin
            rst_cnt <= rst_cnt + 8'h01;
        end
    end
endmodule : rcr_core_model

// File: tb/reset_cause_recorder_bench.sv
// Purpose: directed tests of the reset cause recorder
// Assumes: 20 MHz clock, plain register port, read data one cycle later
// Notes: pulse sources share one vector so one task can fire any of them
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module reset_cause_recorder_bench;
    localparam int E_SWR = 0, E_WDT = 1, E_SLP = 2, E_IDL = 3, E_WCL = 4;
    localparam int E_TRP = 5, E_PPS = 6, E_INS = 7, E_WWR = 8, E_PTR = 9;
    localparam int E_FLW = 10, E_POR = 11, E_BOR = 12, E_UPS = 13;
    localparam logic [3:0] BUSY[5] = '{4'he, 4'hf, 4'hd, 4'he, 4'hf};
    localparam logic [3:0] NEWL[5] = '{4'hd, 4'hd, 4'he, 4'hc, 4'he};
    localparam logic [4:0] TRAP_HIT = 5'b10011;
    localparam logic [23:0] TGT[4] = '{24'h1ff, 24'h200, 24'h3ff, 24'h400};
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cpu_sleep = 0;
    logic external_reset_pin_n = 1, trap_busy = 0, cpu_idle = 0;
    logic [13:0] ev = '0;
    logic [7:0] reg_addr = 8'h00, instr_upper = 8'h00, rst_cnt, cnt_base;
    logic [15:0] reg_wdata = 16'h0000, pps_wdata = 16'h0000, rd_val;
    logic [15:0] reg_rdata, pps_cells, wreg_init_map;
    logic [23:0] flow_target = 24'h0;
    logic [3:0] trap_busy_lvl = 4'h0, trap_new_lvl = 4'h0;
    logic [3:0] wreg_wr_idx = 4'h0, wreg_ptr_idx = 4'h0;
    logic system_reset_line, clock_reinit, wdt_wake;
    int errors = 0, checks_done = 0;

    rcr_reset_cause_recorder dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .por_event(ev[11]),
        .bor_event(ev[12]), .external_reset_pin_n,
        .reset_instr_exec(ev[0]), .wdt_timeout(ev[1]), .cpu_sleep,
        .cpu_idle, .power_save_instruction_sleep_exec(ev[2]),
        .power_save_instruction_idle_exec(ev[3]), .wdt_clear_exec(ev[4]), .trap_busy,
        .trap_busy_lvl, .trap_new(ev[5]), .trap_new_lvl, .pps_wr(ev[6]),
        .pps_wdata, .pps_cells, .instr_exec(ev[7]), .instr_upper,
        .wreg_wr(ev[8]), .wreg_wr_idx, .wreg_ptr_use(ev[9]), .wreg_ptr_idx,
        .flow_change(ev[10]), .flow_target, .system_reset_line,
        .clock_reinit, .wdt_wake, .wreg_init_map);
    rcr_core_model model_u (.sys_clk, .rst, .system_reset_line,
        .pps_wr(ev[6]), .pps_wdata, .upset(ev[13]), .pps_cells, .rst_cnt);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // ---
    // tasks
    // ---
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic fire(input int k);
        @(posedge sys_clk);
        ev[k] <= 1'b1;
        @(posedge sys_clk);
        ev <= '0;
        #1;
    endtask : fire
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_is(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        `CHK("reg_rdata", e, rd_val)
    endtask : reg_is
    // n of ff skips the pulse count where the pulse form is not ours
    task automatic cause_is(input logic [15:0] e, input logic [7:0] n,
                            input bit clr);
        tick(3);
        reg_is(rcr_pkg::ADDR_CAUSE, e);
        if (n !== 8'hff) `CHK("reset pulses", n, rst_cnt - cnt_base)
        cnt_base = rst_cnt;
        if (clr) reg_write(rcr_pkg::ADDR_CAUSE, 16'h0000);
    endtask : cause_is
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // a full run is under 2000 cycles; this leaves wide margin
    initial begin
        #(5000 * 50);
        errors++;
        results();
    end

    // ---
    // tests
    // ---
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        cnt_base = 8'h00;
        tick(2);
        `CHK("init map", 16'h8000, wreg_init_map)
        cause_is(16'h0003, 8'h00, 1'b0);
        reg_is(rcr_pkg::ADDR_CTRL, 16'h0003);
        reg_is(8'h08, 16'h0000);
        reg_write(rcr_pkg::ADDR_CAUSE, 16'hffff);
        cause_is(16'hc2df, 8'h00, 1'b0);
        fire(E_BOR);
        cause_is(16'h0082, 8'hff, 1'b0);
        @(posedge sys_clk) ev[E_POR] <= 1'b1;
        #1 `CHK("clock reinit", 1'b1, clock_reinit)
        @(posedge sys_clk) ev <= '0;
        cause_is(16'h0003, 8'hff, 1'b1);
        done("power flags");
        fire(E_SWR);
        `CHK("reset line", 1'b1, system_reset_line)
        `CHK("clock reinit", 1'b0, clock_reinit)
        tick(1);
        `CHK("reset line", 1'b0, system_reset_line)
        cause_is(16'h0040, 8'h01, 1'b1);
        @(posedge sys_clk) external_reset_pin_n <= 1'b0;
        @(posedge sys_clk) external_reset_pin_n <= 1'b1;
        cause_is(16'h0080, 8'h01, 1'b1);
        done("software and pin");
        @(posedge sys_clk) ev[E_WDT] <= 1'b1;
        #1 `CHK("reset line", 1'b1, system_reset_line)
        @(posedge sys_clk) ev <= '0;
        cause_is(16'h0010, 8'h01, 1'b0);
        fire(E_WCL);
        cause_is(16'h0000, 8'h00, 1'b0);
        @(posedge sys_clk);
        cpu_sleep <= 1'b1;
        ev[E_WDT] <= 1'b1;
        #1 `CHK("reset line", 1'b0, system_reset_line)
        @(posedge sys_clk);
        ev <= '0;
        cpu_sleep <= 1'b0;
        #1 `CHK("wake", 1'b1, wdt_wake)
        @(posedge sys_clk);
        cpu_idle <= 1'b1;
        ev[E_WDT] <= 1'b1;
        #1 `CHK("reset line", 1'b0, system_reset_line)
        @(posedge sys_clk);
        ev <= '0;
        cpu_idle <= 1'b0;
        #1 `CHK("wake", 1'b1, wdt_wake)
        cause_is(16'h0010, 8'h00, 1'b0);
        fire(E_SLP);
        cause_is(16'h0008, 8'h00, 1'b1);
        fire(E_IDL);
        cause_is(16'h0004, 8'h00, 1'b1);
        done("watchdog");
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            trap_busy <= 1'b1;
            trap_busy_lvl <= BUSY[i];
            trap_new_lvl <= NEWL[i];
            fire(E_TRP);
            cause_is(TRAP_HIT[i] ? 16'h8000 : 16'h0, {7'h0, TRAP_HIT[i]},
                     1'b1);
        end
        @(posedge sys_clk) trap_busy <= 1'b0;
        done("traps");
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk) instr_upper <= (i == 0) ? 8'h3f : 8'h3e;
            fire(E_INS);
            cause_is((i == 0) ? 16'h4000 : 16'h0, (i == 0) ? 8'h01 : 8'h00,
                     1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) flow_target <= TGT[i];
            fire(E_FLW);
            cause_is((i == 1 || i == 2) ? 16'h4000 : 16'h0,
                     (i == 1 || i == 2) ? 8'h01 : 8'h00, 1'b1);
        end
        @(posedge sys_clk) wreg_ptr_idx <= 4'hf;
        fire(E_PTR);
        cause_is(16'h0000, 8'h00, 1'b1);
        @(posedge sys_clk) wreg_ptr_idx <= 4'h3;
        fire(E_PTR);
        cause_is(16'h4000, 8'h01, 1'b1);
        @(posedge sys_clk) wreg_wr_idx <= 4'h3;
        fire(E_WWR);
        tick(1);
        `CHK("init map", 16'h8008, wreg_init_map)
        fire(E_PTR);
        cause_is(16'h0000, 8'h00, 1'b1);
        fire(E_SWR);
        fire(E_PTR);
        cause_is(16'h4040, 8'h02, 1'b1);
        done("illegal conditions");
        @(posedge sys_clk) pps_wdata <= 16'h5a5a;
        fire(E_PPS);
        cause_is(16'h0000, 8'h00, 1'b0);
        fire(E_UPS);
        @(posedge sys_clk) pps_wdata <= 16'h5a5b;
        fire(E_PPS);
        cause_is(16'h0200, 8'h01, 1'b1);
        done("pin select shadow");
        results();
    end
endmodule : reset_cause_recorder_bench
